// file: ubd_pkg.sv
// constants shared by the buffer descriptor engine and its helpers
package ubd_pkg;
    // ==========================================================
    // widths and fifo depth
    localparam int RAM_AW     = 9;
    localparam int DATA_W     = 8;
    localparam int BD_W       = 5;
    localparam int EP_W       = 3;
    localparam int CNT_W      = 10;
    localparam int FIFO_DEPTH = 8;
    // rx fifo entry: {no_data, err, last, data}
    localparam int RX_W       = DATA_W + 3;
    localparam int RX_LAST    = DATA_W;
    localparam int RX_ERR     = DATA_W + 1;
    localparam int RX_NODATA  = DATA_W + 2;
    // ==========================================================
    // descriptor byte offsets
    localparam logic [1:0] OFS_STAT = 2'h0;
    localparam logic [1:0] OFS_CNT  = 2'h1;
    localparam logic [1:0] OFS_ADRL = 2'h2;
    localparam logic [1:0] OFS_ADRH = 2'h3;
    // ==========================================================
    // status byte fields
    localparam int OWN_BIT   = 7;
    localparam int DTS_BIT   = 6;
    localparam int TGLEN_BIT = 3;
    localparam int STALL_BIT = 2;
    localparam int PID_LSB   = 2;
    localparam int BC9_BIT   = 1;
    localparam int BC8_BIT   = 0;
    // ==========================================================
    // token pids and handshake codes
    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;
    localparam logic [1:0] HS_ACK    = 2'h0;
    localparam logic [1:0] HS_NAK    = 2'h1;
    localparam logic [1:0] HS_STALL  = 2'h2;
endpackage

// file: ubd_fifo.sv
// receive byte fifo between the packet layer and the engine
module ubd_fifo #(
    parameter int W     = 11,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic          next_in_ready;
    logic          push;
    logic          pop;

    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = CW'(count + CW'(push) - CW'(pop));
        next_in_ready = (next_count < CW'(DEPTH));
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// file: ubd_dpram.sv
// dual port byte ram shared by cpu and engine
module ubd_dpram #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    // cpu port
    input  wire logic [AW-1:0] a_addr,
    input  wire logic          a_we,
    input  wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0]      a_rdata,
    // engine port
    input  wire logic [AW-1:0] b_addr,
    input  wire logic          b_we,
    input  wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0]      b_rdata
);
    logic [DW-1:0] mem [2**AW];

    // no arbitration: same-address writes from both ports are a firmware fault
    always_ff @(posedge clk_sys) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule

// file: ubd_engine.sv
// buffer descriptor engine of the usb serial interface engine
// Operation
// - ownership flag decides who may modify descriptor
// - status byte readable by both at any time
// - engine writes pid and count while owning
// - engine clears ownership flag on completion
// - toggle checked against expected bit when enabled
// - toggle mismatch: drop data, ack, no update
// - good out packet: ack, release, done, update
// - stall bit: answer stall, set endpoint stall
// - stall keeps descriptor; setup clears and releases
// - byte count is ten bits, 0 to 1023
// - count above eight bits carries into status
// - in: send count bytes, write back sent
// - out: count is maximum, write back received
// - oversized out packet: nak, count unchanged
// - buffer address used without any check
// - expected toggle ignored unless checking enabled
// - engine returns pid in status bits 5:2
// - disabled endpoint descriptors are plain ram
// - transfer done flag marks transaction complete
module ubd_engine #(
    parameter int NUM_EP     = 8,
    parameter int FIFO_DEPTH = ubd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rstn,
    // cpu access to usb ram
    input  wire logic [ubd_pkg::RAM_AW-1:0]   cpu_addr,
    input  wire logic                         cpu_we,
    input  wire logic [ubd_pkg::DATA_W-1:0]   cpu_wdata,
    output logic [ubd_pkg::DATA_W-1:0]        cpu_rdata,
    // endpoint control and transfer status
    input  wire logic [NUM_EP-1:0]            ep_enable,
    input  wire logic [NUM_EP-1:0]            ep_stall_clear,
    output logic [NUM_EP-1:0]                 endpoint_stall_flag,
    output logic                              stall_event,
    input  wire logic                         trn_clear,
    output logic                              transfer_done_flag,
    output logic [ubd_pkg::BD_W:0]            transfer_status,
    // token from packet layer
    input  wire logic                         tok_valid,
    output logic                              tok_ready,
    input  wire logic [3:0]                   tok_pid,
    input  wire logic [ubd_pkg::EP_W-1:0]     tok_ep,
    input  wire logic [ubd_pkg::BD_W-1:0]     tok_bd,
    input  wire logic                         tok_data_odd,
    // received data bytes
    input  wire logic                         rx_valid,
    output logic                              rx_ready,
    input  wire logic [ubd_pkg::DATA_W-1:0]   rx_data,
    input  wire logic                         rx_last,
    input  wire logic                         rx_err,
    input  wire logic                         rx_nodata,
    // transmitted data bytes
    output logic                              tx_valid,
    input  wire logic                         tx_ready,
    output logic [ubd_pkg::DATA_W-1:0]        tx_data,
    output logic                              tx_last,
    // handshake to packet layer
    output logic                              hs_valid,
    output logic [1:0]                        hs_code
);
    import ubd_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_RD_STAT, S_RD_CNT, S_RD_ADRL, S_RD_ADRH, S_DECIDE,
        S_TX_RD, S_TX_LOAD, S_TX_HOLD, S_RX, S_WR_CNT, S_WR_STAT, S_HS
    } ubd_state_t;

    // ==========================================================
    // ram and fifo
    logic [RAM_AW-1:0] b_addr;
    logic              b_we;
    logic [DATA_W-1:0] b_wdata;
    logic [DATA_W-1:0] b_rdata;
    logic              f_out_valid;
    logic              f_out_ready;
    logic [RX_W-1:0]   f_out;

    ubd_dpram #(.AW(RAM_AW), .DW(DATA_W)) u_ram (
        .clk_sys (clk_sys),
        .a_addr  (cpu_addr),
        .a_we    (cpu_we),
        .a_wdata (cpu_wdata),
        .a_rdata (cpu_rdata),
        .b_addr  (b_addr),
        .b_we    (b_we),
        .b_wdata (b_wdata),
        .b_rdata (b_rdata)
    );

    ubd_fifo #(.W(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_nodata, rx_err, rx_last, rx_data}),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out)
    );

    // ==========================================================
    // engine state
    ubd_state_t        st, next_st;
    logic [BD_W-1:0]   bd, next_bd;
    logic [EP_W-1:0]   ep, next_ep;
    logic [3:0]        pid, next_pid;
    logic              odd, next_odd;
    logic [DATA_W-1:0] stat, next_stat;
    logic [DATA_W-1:0] cnt8, next_cnt8;
    logic [DATA_W-1:0] adrl, next_adrl;
    logic [RAM_AW-1:0] base, next_base;
    logic [CNT_W-1:0]  idx, next_idx;
    logic [CNT_W-1:0]  wb, next_wb;
    logic              bad, next_bad;
    logic              over, next_over;
    logic [1:0]        pend, next_pend;
    logic              next_tx_valid, next_tx_last, next_hs_valid, next_stall_event;
    logic [DATA_W-1:0] next_tx_data;
    logic [1:0]        next_hs_code;
    logic              next_done;
    logic [BD_W:0]     next_tstatus;
    logic [NUM_EP-1:0] next_stall_flag, set_stall;
    logic              set_done;
    logic [CNT_W-1:0]  lim;
    logic              have_byte, room, pop_last;

    // ten-bit count: low byte plus two status bits
    assign lim       = {stat[BC9_BIT], stat[BC8_BIT], cnt8};
    assign have_byte = f_out_valid && !f_out[RX_NODATA];
    assign room      = (idx != lim);
    assign pop_last  = (st == S_RX) && f_out_valid && f_out[RX_LAST];

    always_comb begin
        next_st = st; next_bd = bd; next_ep = ep; next_pid = pid; next_odd = odd;
        next_stat = stat; next_cnt8 = cnt8; next_adrl = adrl; next_base = base;
        next_idx = idx; next_wb = wb; next_bad = bad; next_over = over; next_pend = pend;
        next_tx_valid = tx_valid; next_tx_last = tx_last; next_tx_data = tx_data;
        next_hs_valid = 1'b0; next_hs_code = hs_code; next_stall_event = 1'b0;
        set_done = 1'b0; set_stall = '0; f_out_ready = 1'b0;
        b_we = 1'b0; b_wdata = '0; b_addr = RAM_AW'({bd, OFS_STAT});
        case (st)
            S_IDLE: begin
                // drop bytes of a refused or ignored packet
                f_out_ready = 1'b1;
                if (tok_valid) begin
                    next_bd = tok_bd; next_ep = tok_ep; next_pid = tok_pid; next_odd = tok_data_odd;
                    next_st = S_RD_STAT;
                end
            end
            S_RD_STAT: next_st = S_RD_CNT;
            S_RD_CNT: begin
                b_addr = RAM_AW'({bd, OFS_CNT});
                next_stat = b_rdata;
                next_st = S_RD_ADRL;
            end
            S_RD_ADRL: begin
                b_addr = RAM_AW'({bd, OFS_ADRL});
                next_cnt8 = b_rdata;
                next_st = S_RD_ADRH;
            end
            S_RD_ADRH: begin
                b_addr = RAM_AW'({bd, OFS_ADRH});
                next_adrl = b_rdata;
                next_st = S_DECIDE;
            end
            S_DECIDE: begin
                // address pair taken as is, no range check
                next_base = RAM_AW'({b_rdata, adrl});
                next_idx = '0; next_over = 1'b0;
                next_bad = stat[TGLEN_BIT] && (odd != stat[DTS_BIT]);
                if (!ep_enable[ep]) begin
                    next_st = S_IDLE;
                end else if (!stat[OWN_BIT]) begin
                    next_pend = HS_NAK; next_st = S_HS;
                end else if (stat[STALL_BIT] && pid != PID_SETUP) begin
                    set_stall[ep] = 1'b1; next_stall_event = 1'b1;
                    next_pend = HS_STALL; next_st = S_HS;
                end else if (pid == PID_IN) begin
                    next_wb = lim;
                    next_st = (lim == '0) ? S_WR_CNT : S_TX_RD;
                end else begin
                    next_st = S_RX;
                end
            end
            S_TX_RD: begin
                b_addr = RAM_AW'(base + idx[RAM_AW-1:0]);
                next_st = S_TX_LOAD;
            end
            S_TX_LOAD: begin
                next_tx_data = b_rdata; next_tx_valid = 1'b1;
                next_tx_last = (CNT_W'(idx + 1'b1) == lim);
                next_st = S_TX_HOLD;
            end
            S_TX_HOLD: begin
                if (tx_ready) begin
                    next_tx_valid = 1'b0; next_tx_last = 1'b0;
                    next_idx = CNT_W'(idx + 1'b1);
                    next_st = tx_last ? S_WR_CNT : S_TX_RD;
                end
            end
            S_RX: begin
                f_out_ready = 1'b1;
                if (have_byte && !room) begin
                    next_over = 1'b1;
                end
                if (have_byte && room) begin
                    next_idx = CNT_W'(idx + 1'b1);
                    b_addr = RAM_AW'(base + idx[RAM_AW-1:0]);
                    b_we = !bad;
                    b_wdata = f_out[DATA_W-1:0];
                end
                if (pop_last) begin
                    next_wb = next_idx;
                    next_pend = bad ? HS_ACK : HS_ACK;
                    if (f_out[RX_ERR]) begin
                        next_st = S_IDLE;
                    end else if (next_over) begin
                        next_pend = HS_NAK; next_st = S_HS;
                    end else if (bad) begin
                        next_st = S_HS;
                    end else begin
                        next_st = S_WR_CNT;
                    end
                end
            end
            S_WR_CNT: begin
                b_addr = RAM_AW'({bd, OFS_CNT}); b_we = 1'b1;
                b_wdata = wb[DATA_W-1:0];
                next_st = S_WR_STAT;
            end
            S_WR_STAT: begin
                // whole status byte in one write, ownership released with it
                b_we = 1'b1;
                b_wdata = {1'b0, stat[DTS_BIT], pid, wb[CNT_W-1], wb[CNT_W-2]};
                set_done = 1'b1;
                next_pend = HS_ACK;
                next_st = (pid == PID_IN) ? S_IDLE : S_HS;
            end
            S_HS: begin
                next_hs_valid = 1'b1; next_hs_code = pend;
                next_st = S_IDLE;
            end
            default: next_st = S_IDLE;
        endcase
        // set wins over a simultaneous clear
        next_done = (transfer_done_flag && !trn_clear) || set_done;
        next_tstatus = set_done ? {bd, (pid == PID_IN)} : transfer_status;
        next_stall_flag = (endpoint_stall_flag & ~ep_stall_clear) | set_stall;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= S_IDLE; bd <= '0; ep <= '0; pid <= '0; odd <= 1'b0;
            stat <= '0; cnt8 <= '0; adrl <= '0; base <= '0; idx <= '0; wb <= '0;
            bad <= 1'b0; over <= 1'b0; pend <= HS_ACK;
            tx_valid <= 1'b0; tx_last <= 1'b0; tx_data <= '0;
            hs_valid <= 1'b0; hs_code <= HS_ACK; stall_event <= 1'b0;
            transfer_done_flag <= 1'b0; transfer_status <= '0;
            endpoint_stall_flag <= '0; tok_ready <= 1'b0;
        end else begin
            st <= next_st; bd <= next_bd; ep <= next_ep; pid <= next_pid; odd <= next_odd;
            stat <= next_stat; cnt8 <= next_cnt8; adrl <= next_adrl; base <= next_base;
            idx <= next_idx; wb <= next_wb; bad <= next_bad; over <= next_over; pend <= next_pend;
            tx_valid <= next_tx_valid; tx_last <= next_tx_last; tx_data <= next_tx_data;
            hs_valid <= next_hs_valid; hs_code <= next_hs_code; stall_event <= next_stall_event;
            transfer_done_flag <= next_done; transfer_status <= next_tstatus;
            endpoint_stall_flag <= next_stall_flag; tok_ready <= (next_st == S_IDLE);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence seq_decide;
        st == S_DECIDE && ep_enable[ep];
    endsequence
    sequence seq_stall_hit;
        seq_decide ##0 stat[OWN_BIT] && stat[STALL_BIT] && pid != PID_SETUP;
    endsequence

    a_nak_unowned: assert property (seq_decide ##0 !stat[OWN_BIT] |-> ##2 hs_valid && hs_code == HS_NAK)
        else $error("unowned descriptor not answered with nak");
    a_stall_flag: assert property (seq_stall_hit |=> endpoint_stall_flag[$past(ep)] && stall_event)
        else $error("stall flag not set on stalled descriptor");
    a_stall_keeps: assert property (seq_stall_hit |-> !b_we ##1 !b_we ##1 hs_valid && hs_code == HS_STALL)
        else $error("stalled descriptor modified or no stall answer");
    a_own_release: assert property (st == S_WR_STAT |-> b_we && !b_wdata[OWN_BIT] && $past(st) == S_WR_CNT)
        else $error("status write does not release ownership");
    a_count_carry: assert property (st == S_WR_STAT |-> b_wdata[1:0] == wb[9:8] && $past(b_wdata) == wb[7:0])
        else $error("count carry not written to status byte");
    a_pid_return: assert property (st == S_WR_STAT |-> b_wdata[5:2] == pid)
        else $error("pid not returned in status bits");
    a_mismatch_drop: assert property (st == S_RX && bad |-> !b_we)
        else $error("mismatched packet written to ram");
    a_over_nak: assert property (pop_last && !f_out[RX_ERR] && next_over |=> st == S_HS ##1 hs_code == HS_NAK)
        else $error("oversized packet not refused with nak");
    a_done_flag: assert property (st == S_WR_STAT |=> transfer_done_flag)
        else $error("done flag not raised after completion");
    a_disabled_ep: assert property (st == S_DECIDE && !ep_enable[ep] |=> st == S_IDLE ##1 !hs_valid)
        else $error("disabled endpoint descriptor used");
endmodule

// file: ubd_host_model.sv
// host-side packet model: token source, out data source, in data sink
module ubd_host_model (
    // clock
    input  wire logic                       clk_sys,
    // token
    output logic                            tok_valid,
    input  wire logic                       tok_ready,
    output logic [3:0]                      tok_pid,
    output logic [ubd_pkg::EP_W-1:0]        tok_ep,
    output logic [ubd_pkg::BD_W-1:0]        tok_bd,
    output logic                            tok_data_odd,
    // out data
    output logic                            rx_valid,
    input  wire logic                       rx_ready,
    output logic [ubd_pkg::DATA_W-1:0]      rx_data,
    output logic                            rx_last,
    output logic                            rx_err,
    output logic                            rx_nodata,
    // in data and handshake
    input  wire logic                       tx_valid,
    output logic                            tx_ready,
    input  wire logic [ubd_pkg::DATA_W-1:0] tx_data,
    input  wire logic                       hs_valid,
    input  wire logic [1:0]                 hs_code
);
    timeunit 1ns;
    timeprecision 1ps;
    import ubd_pkg::*;
    // ==========================================
    // state seen by the bench
    logic       slow = 1'b0;
    int         hs_cnt = 0;
    logic [1:0] hs_last = 2'h0;
    logic [7:0] tx_q[$];
    initial begin
        {tok_valid, tok_pid, tok_ep, tok_bd, tok_data_odd} = '0;
        {rx_valid, rx_data, rx_last, rx_err, rx_nodata} = '0;
        tx_ready = 1'b1;
    end
    // ==========================================
    // in data sink and handshake capture
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) tx_q.push_back(tx_data);
        if (hs_valid) hs_last <= hs_code;
        if (hs_valid) hs_cnt <= hs_cnt + 1;
    end
    // stall every other cycle when slow
    always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
    // ==========================================
    // requests, entered at a falling edge
    task automatic send_tok(input logic [3:0] p, input logic [2:0] e, input logic [4:0] b,
                            input logic odd, output bit ok);
        ok = 1'b0;
        {tok_pid, tok_ep, tok_bd, tok_data_odd} = {p, e, b, odd};
        tok_valid = 1'b1;
        for (int n = 0; n < 60 && !ok; n++) begin
            ok = (tok_ready === 1'b1);
            @(negedge clk_sys);
        end
        tok_valid = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, input logic last, input logic err, output bit ok);
        ok = 1'b0;
        {rx_data, rx_last, rx_err} = {d, last, err};
        rx_valid = 1'b1;
        for (int n = 0; n < 60 && !ok; n++) begin
            ok = (rx_ready === 1'b1);
            @(negedge clk_sys);
        end
        // released data line does not keep its value
        if (last) {rx_valid, rx_data} = {1'b0, ~d};
    endtask
endmodule

// file: tb.sv
// self-checking bench for the buffer descriptor engine
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ubd_pkg::*;
    // ==========================================
    // nets and counters
    logic clk_sys = 1'b0, rstn = 1'b0, cpu_we = 1'b0, trn_clear = 1'b0, m;
    logic [8:0] cpu_addr = '0;
    logic [7:0] cpu_wdata = '0, cpu_rdata, exp_b, endpoint_stall_flag;
    logic [7:0] ep_enable = 8'hDF, ep_stall_clear = 8'h00;
    logic transfer_done_flag, tok_valid, tok_ready, tok_data_odd, rx_valid, rx_ready, rx_last, rx_err;
    logic rx_nodata, tx_valid, tx_ready, hs_valid;
    logic [5:0] transfer_status;
    logic [3:0] tok_pid;
    logic [2:0] tok_ep;
    logic [4:0] tok_bd;
    logic [7:0] rx_data, tx_data;
    logic [1:0] hs_code;
    int fail_count = 0;
    int cmp_count = 0;
    bit ok;
    always #10 clk_sys = ~clk_sys;
    ubd_engine ubd_engine_inst (.clk_sys, .rstn, .cpu_addr, .cpu_we, .cpu_wdata, .cpu_rdata, .ep_enable,
        .ep_stall_clear, .endpoint_stall_flag, .stall_event(), .trn_clear, .transfer_done_flag,
        .transfer_status, .tok_valid, .tok_ready, .tok_pid, .tok_ep, .tok_bd, .tok_data_odd, .rx_valid,
        .rx_ready, .rx_data, .rx_last, .rx_err, .rx_nodata, .tx_valid, .tx_ready, .tx_data, .tx_last(),
        .hs_valid, .hs_code);
    ubd_host_model host_inst (.clk_sys, .tok_valid, .tok_ready, .tok_pid, .tok_ep, .tok_bd, .tok_data_odd,
        .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_err, .rx_nodata, .tx_valid, .tx_ready, .tx_data,
        .hs_valid, .hs_code);
    // ==========================================
    // tasks, entered at a falling edge
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic stuck();
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("Error at %0t: byte %h expected %h", $time, got, exp);
    endtask
    task automatic chk_hs(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("Error at %0t: handshake %h expected %h", $time, got, exp);
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        {cpu_addr, cpu_wdata, cpu_we} = {a, d, 1'b1};
        @(negedge clk_sys);
        cpu_we = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        cpu_addr = a;
        @(negedge clk_sys);
        chk_byte(cpu_rdata, exp);
    endtask
    task automatic arm(input logic [4:0] b, input logic [7:0] st, input logic [7:0] cnt, input logic [8:0] adr);
        wr({2'b00, b, 2'h1}, cnt);
        wr({2'b00, b, 2'h2}, adr[7:0]);
        wr({2'b00, b, 2'h3}, {7'h00, adr[8]});
        wr({2'b00, b, 2'h0}, st & 8'h7F);
        wr({2'b00, b, 2'h0}, st);
    endtask
    task automatic tok(input logic [3:0] p, input logic [2:0] e, input logic [4:0] b, input logic odd);
        host_inst.send_tok(p, e, b, odd, ok);
        if (!ok) stuck();
    endtask
    task automatic put(input logic [7:0] d, input logic last, input logic err);
        host_inst.send_byte(d, last, err, ok);
        if (!ok) stuck();
    endtask
    task automatic hs_wait(input logic [1:0] exp);
        int n0 = host_inst.hs_cnt;
        for (int n = 0; n < 700 && host_inst.hs_cnt == n0; n++) @(negedge clk_sys);
        if (host_inst.hs_cnt == n0) stuck();
        chk_hs(host_inst.hs_last, exp);
    endtask
    task automatic quiet();
        int n0 = host_inst.hs_cnt;
        repeat (30) @(negedge clk_sys);
        chk_byte({7'h00, host_inst.hs_cnt != n0}, 8'h00);
    endtask
    task automatic good(input logic odd);
        tok(PID_OUT, 3'd1, 5'd3, odd);
        put(8'h42, 1'b1, 1'b0);
        hs_wait(HS_ACK);
    endtask
    task automatic clr();
        {trn_clear, ep_stall_clear} = {1'b1, 8'hFF};
        @(negedge clk_sys);
        {trn_clear, ep_stall_clear} = {1'b0, 8'h00};
        @(negedge clk_sys);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (2) @(negedge clk_sys);
        // i: check enable, expected toggle, packet toggle
        for (int i = 0; i < 8; i++) begin
            arm(5'd3, {1'b1, i[1], 2'b00, i[2], 3'b000}, 8'h04, 9'h100);
            tok(PID_OUT, 3'd1, 5'd3, i[0]);
            put(8'(i), 1'b1, 1'b0);
            hs_wait(HS_ACK);
            m = !i[2] || (i[1] == i[0]);
            if (m) exp_b = 8'(i);
            rd_chk(9'h00C, m ? {1'b0, i[1], PID_OUT, 2'b00} : {1'b1, i[1], 2'b00, i[2], 3'b000});
            rd_chk(9'h00D, m ? 8'h01 : 8'h04);
            rd_chk(9'h100, exp_b);
            chk_byte({7'h00, transfer_done_flag}, {7'h00, m});
            if (m) chk_byte({2'b00, transfer_status}, 8'h06);
            if (!m) begin
                good(i[1]);
                exp_b = 8'h42;
            end
            clr();
        end
        $display("test toggle done");
        arm(5'd3, 8'h80, 8'h04, 9'h100);
        tok(PID_OUT, 3'd1, 5'd3, 1'b0);
        put(8'h99, 1'b1, 1'b1);
        quiet();
        rd_chk(9'h00C, 8'h80);
        good(1'b0);
        arm(5'd3, 8'h81, 8'h2C, 9'h0C0);
        tok(PID_OUT, 3'd1, 5'd3, 1'b0);
        for (int k = 0; k < 260; k++) put(8'(k), k == 259, 1'b0);
        hs_wait(HS_ACK);
        rd_chk(9'h00C, 8'h05);
        rd_chk(9'h00D, 8'h04);
        rd_chk(9'h1C3, 8'h03);
        $display("test error and carry done");
        arm(5'd3, 8'h80, 8'h02, 9'h100);
        tok(PID_OUT, 3'd1, 5'd3, 1'b0);
        for (int k = 0; k < 3; k++) put(8'hF0, k == 2, 1'b0);
        hs_wait(HS_NAK);
        rd_chk(9'h00D, 8'h02);
        rd_chk(9'h00C, 8'h80);
        good(1'b0);
        tok(PID_IN, 3'd1, 5'd3, 1'b0);
        hs_wait(HS_NAK);
        rd_chk(9'h00C, 8'h04);
        tok(PID_OUT, 3'd1, 5'd3, 1'b0);
        put(8'h77, 1'b1, 1'b0);
        hs_wait(HS_NAK);
        $display("test overflow and cpu owned done");
        arm(5'd3, 8'h84, 8'h04, 9'h100);
        tok(PID_IN, 3'd2, 5'd3, 1'b0);
        hs_wait(HS_STALL);
        chk_byte(endpoint_stall_flag, 8'h04);
        rd_chk(9'h00C, 8'h84);
        tok(PID_SETUP, 3'd2, 5'd3, 1'b0);
        put(8'h5A, 1'b1, 1'b0);
        hs_wait(HS_ACK);
        rd_chk(9'h00C, 8'h34);
        rd_chk(9'h100, 8'h5A);
        clr();
        $display("test stall done");
        wr(9'h100, 8'h11);
        wr(9'h101, 8'h22);
        arm(5'd5, 8'h80, 8'h02, 9'h100);
        host_inst.slow = 1'b1;
        tok(PID_IN, 3'd1, 5'd5, 1'b0);
        for (int n = 0; n < 200 && transfer_done_flag !== 1'b1; n++) @(negedge clk_sys);
        if (transfer_done_flag !== 1'b1) stuck();
        chk_byte(8'(host_inst.tx_q.size()), 8'h02);
        chk_byte(host_inst.tx_q[1], 8'h22);
        rd_chk(9'h015, 8'h02);
        rd_chk(9'h014, 8'h24);
        chk_byte({2'b00, transfer_status}, 8'h0B);
        $display("test in done");
        arm(5'd6, 8'h80, 8'h04, 9'h100);
        tok(PID_IN, 3'd5, 5'd6, 1'b0);
        quiet();
        rd_chk(9'h018, 8'h80);
        $display("test disabled endpoint done");
        tally_and_finish();
    end
endmodule
